/* core/pmc_pkg.sv */
// Constants, types and helper function of the PSU management controller
// ---------------------------------------------------------------------
// Function
// - Own address is 1100 plus strap bits
// - Open strap reads one, grounded reads zero
// - Address LSB zero writes, one reads
// - Accept writes to all-zero broadcast address
// - Broadcast read flags invalid command
// - Software margin overrides hardware setpoint permanently
// - Bias power restart follows hardware setpoint
// - Remote pin or command off turns off
// - Output enabled only while interlock low
// - Over-temperature warning low ten seconds before shutdown
// - Auto restart on cool-down releases warning
// - Fault output on internal shutdown
// - Drive input-in-range and output-present flags
// - Alert low on state change or error
// - Status read-back clears non-communication alarms, alert
// - Persisting alarm re-latches without new alert
// - Every transaction carries checked PEC byte
// - Only storable parameters go to non-volatile memory
// - Auto restart default, changeable by store
// - Reinitialize serial interface after five idle seconds
// - Alert on first state change
// - Unsupported read returns zero, flags, alerts
// - Bus low 35 ms aborts transaction
// - PEC is CRC-8, polynomial 07, all bytes
package pmc_pkg;
  // ---------------------------------------------------------------------
  // Addresses and commands
  // ---------------------------------------------------------------------
  localparam logic [3:0] ADDR_HI = 4'hc;
  localparam logic [6:0] ADDR_BCAST = 7'h00;
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_CLEAR = 8'h03;
  localparam logic [7:0] CMD_STORE = 8'h11;
  localparam logic [7:0] CMD_MARGIN = 8'h21;
  localparam logic [7:0] CMD_SETPT = 8'h8b;
  localparam logic [7:0] CMD_STATUS = 8'h79;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam int OP_ON_BIT = 7;
  localparam int STORE_AR_BIT = 0;
  // ---------------------------------------------------------------------
  // Status bit positions and reset values
  // ---------------------------------------------------------------------
  localparam int SB_PEC = 0;
  localparam int SB_CMD = 1;
  localparam int SB_DATA = 2;
  localparam logic [7:0] COMM_MASK = 8'h07;
  localparam logic [7:0] ALL_MASK = 8'hff;
  localparam logic OP_ON_RST = 1'b1;
  localparam logic AR_RST = 1'b1;
  localparam logic [7:0] SETPT_RST = 8'h00;
  // ---------------------------------------------------------------------
  // Framing counts
  // ---------------------------------------------------------------------
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BIT_ACK = 4'h9;
  localparam logic [2:0] NB_NODATA = 3'h2;
  localparam logic [2:0] NB_DATA = 3'h3;
  localparam logic [2:0] NB_MAX = 3'h7;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int CLK_KHZ = 40000;
  localparam int T_IDLE_MS = 5000;
  localparam int T_STUCK_MS = 35;
  localparam int T_OTW_MS = 10000;
  localparam int CNT_W = 29;
  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {PS_IDLE, PS_RX, PS_TX, PS_SKIP} pmc_state_type;
  typedef struct packed {
    logic scl;
    logic sda;
    logic [2:0] strap;
    logic remote_on;
    logic interlock;
    logic ot;
    logic ov;
    logic in_ok;
    logic vout_ok;
    logic [7:0] vprog;
  } pmc_pins_type;
  typedef struct packed {
    logic out_bad;
    logic in_bad;
    logic fault;
    logic ot;
  } pmc_cond_type;

  function automatic logic [7:0] pmc_crc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
endpackage

/* core/pmc_ctrl_status.sv */
`timescale 1ns/10ps
// PSU management controller: serial slave, alert, setpoint and output control
module pmc_ctrl_status
  import pmc_pkg::*;
#(
  parameter int IDLE_CYC = T_IDLE_MS * CLK_KHZ,
  parameter int STUCK_CYC = T_STUCK_MS * CLK_KHZ,
  parameter int OTW_CYC = T_OTW_MS * CLK_KHZ
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  output logic o_alert_o,
  output logic o_alert_oe,
  input wire logic i_addr_strap_bit2,
  input wire logic i_addr_strap_bit1,
  input wire logic i_addr_strap_bit0,
  input wire logic [7:0] i_vprog_code,
  output logic [7:0] o_setpoint,
  output logic o_sw_margin,
  input wire logic i_remote_on,
  input wire logic i_interlock,
  output logic o_main_on,
  input wire logic i_ot_cond,
  input wire logic i_ov_shutdown,
  input wire logic i_input_ok,
  input wire logic i_vout_ok,
  output logic o_ot_warn_n,
  output logic o_fault,
  output logic o_input_in_range_flag,
  output logic o_output_present_flag,
  input wire logic i_nvm_auto_restart,
  output logic o_nvm_store,
  output logic o_nvm_auto_restart
);
  localparam logic [CNT_W-1:0] IDLE_M1 = CNT_W'(IDLE_CYC - 1);
  localparam logic [CNT_W-1:0] STUCK_M1 = CNT_W'(STUCK_CYC - 1);
  localparam logic [CNT_W-1:0] OTW_M1 = CNT_W'(OTW_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  if (IDLE_CYC < 2 || STUCK_CYC < 2 || OTW_CYC < 2 || IDLE_CYC > 2**CNT_W ||
      STUCK_CYC > 2**CNT_W || OTW_CYC > 2**CNT_W) begin : g_bad_count
    $error("pmc_ctrl_status: timing count out of range");
  end

  // ---------------------------------------------------------------------
  // Link domain: bits taken on the serial clock rise
  // ---------------------------------------------------------------------
  logic bit_ff;
  logic bit_tgl_ff;
  always_ff @(posedge i_scl_clk or posedge i_rst) begin
    if (i_rst) begin
      bit_ff <= 1'b0;
      bit_tgl_ff <= 1'b0;
    end else begin
      bit_ff <= i_sda;
      bit_tgl_ff <= ~bit_tgl_ff;
    end
  end

  // ---------------------------------------------------------------------
  // Pin synchronisers and bus conditions
  // ---------------------------------------------------------------------
  pmc_pins_type pins_raw, pins_m_ff, pins_s_ff;
  logic tgl_m_ff, tgl_s_ff, tgl_d_ff, scl_d_ff, sda_d_ff;
  assign pins_raw = '{scl: i_scl, sda: i_sda, remote_on: i_remote_on,
                      strap: {i_addr_strap_bit2, i_addr_strap_bit1, i_addr_strap_bit0},
                      interlock: i_interlock, ot: i_ot_cond, ov: i_ov_shutdown,
                      in_ok: i_input_ok, vout_ok: i_vout_ok, vprog: i_vprog_code};
  always_ff @(posedge i_clk) begin
    pins_m_ff <= pins_raw;
    pins_s_ff <= pins_m_ff;
    tgl_m_ff <= bit_tgl_ff;
    tgl_s_ff <= tgl_m_ff;
    tgl_d_ff <= tgl_s_ff;
    scl_d_ff <= pins_s_ff.scl;
    sda_d_ff <= pins_s_ff.sda;
  end

  wire bit_ev = tgl_s_ff ^ tgl_d_ff;
  wire scl_fall = scl_d_ff & ~pins_s_ff.scl;
  wire bus_start = pins_s_ff.scl & scl_d_ff & sda_d_ff & ~pins_s_ff.sda;
  wire bus_stop = pins_s_ff.scl & scl_d_ff & ~sda_d_ff & pins_s_ff.sda;
  wire bus_move = (pins_s_ff.scl != scl_d_ff) | (pins_s_ff.sda != sda_d_ff);

  // ---------------------------------------------------------------------
  // Strap capture after reset and bus watchdogs
  // ---------------------------------------------------------------------
  logic [2:0] strap_ff;
  logic [1:0] strap_cnt_ff;
  logic [CNT_W-1:0] act_cnt_ff, low_cnt_ff;
  wire idle_to = act_cnt_ff == IDLE_M1;
  wire stuck = low_cnt_ff == STUCK_M1;
  wire link_abort = idle_to | stuck;
  wire [6:0] own_addr = {ADDR_HI, strap_ff};
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      strap_ff <= 3'h7;
      strap_cnt_ff <= 2'h0;
      act_cnt_ff <= '0;
      low_cnt_ff <= '0;
    end else begin
      if (strap_cnt_ff != STRAP_WAIT) begin
        strap_cnt_ff <= strap_cnt_ff + 2'h1;
        strap_ff <= pins_s_ff.strap;
      end
      act_cnt_ff <= (bus_move | idle_to) ? '0 : act_cnt_ff + CNT_ONE;
      low_cnt_ff <= ((pins_s_ff.scl & pins_s_ff.sda) | bus_move | stuck) ? '0 :
                    low_cnt_ff + CNT_ONE;
    end
  end

  // ---------------------------------------------------------------------
  // Serial protocol engine
  // ---------------------------------------------------------------------
  pmc_state_type state_ff, nxt_state;
  logic [3:0] bitcnt_ff, nxt_bitcnt;
  logic [7:0] sh_ff, nxt_sh, cmd_ff, nxt_cmd, dat_ff, nxt_dat, last_ff, nxt_last;
  logic [7:0] crc_ff, nxt_crc, crc_prev_ff, nxt_crc_prev, tx_ff, nxt_tx;
  logic [2:0] nb_ff, nxt_nb;
  logic addr_ph_ff, nxt_addr_ph, ack_ff, nxt_ack, go_tx_ff, nxt_go_tx;
  logic tx_idx_ff, nxt_tx_idx, sda_oe_ff, nxt_sda_oe, rd_done_ff, nxt_rd_done;
  logic ev_exec, ev_pecerr, ev_cmderr, ev_rdclr;
  logic [7:0] stat_ff;
  logic [7:0] setpoint_ff;

  function automatic logic cmd_known(input logic [7:0] c);
    return c == CMD_OPERATION || c == CMD_CLEAR || c == CMD_STORE ||
           c == CMD_MARGIN || c == CMD_SETPT || c == CMD_STATUS;
  endfunction

  wire [7:0] nsh = {sh_ff[6:0], bit_ff};
  wire byte_done = bit_ev && state_ff == PS_RX && bitcnt_ff == BITS_BYTE - 4'h1;
  wire addr_own = nsh[7:1] == own_addr;
  wire addr_bc = nsh[7:1] == ADDR_BCAST;
  wire [7:0] rd_data = (cmd_ff == CMD_STATUS) ? stat_ff :
                       (cmd_ff == CMD_SETPT) ? setpoint_ff : READ_ZERO;

  always_comb begin
    nxt_state = state_ff;
    nxt_bitcnt = bitcnt_ff;
    nxt_sh = sh_ff;
    nxt_cmd = cmd_ff;
    nxt_dat = dat_ff;
    nxt_last = last_ff;
    nxt_crc = crc_ff;
    nxt_crc_prev = crc_prev_ff;
    nxt_tx = tx_ff;
    nxt_nb = nb_ff;
    nxt_addr_ph = addr_ph_ff;
    nxt_ack = ack_ff;
    nxt_go_tx = go_tx_ff;
    nxt_tx_idx = tx_idx_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_rd_done = rd_done_ff;
    ev_exec = 1'b0;
    ev_pecerr = 1'b0;
    ev_cmderr = 1'b0;
    ev_rdclr = 1'b0;
    if (link_abort) begin
      nxt_state = PS_IDLE;
      nxt_sda_oe = 1'b0;
    end else if (bus_start) begin
      nxt_state = PS_RX;
      nxt_bitcnt = 4'h0;
      nxt_addr_ph = 1'b1;
      nxt_go_tx = 1'b0;
      nxt_sda_oe = 1'b0;
      nxt_rd_done = 1'b0;
      if (state_ff == PS_IDLE || state_ff == PS_SKIP) begin
        nxt_crc = CRC_INIT;
        nxt_nb = 3'h0;
      end
    end else if (bus_stop) begin
      nxt_state = PS_IDLE;
      nxt_sda_oe = 1'b0;
      if (state_ff == PS_RX && nb_ff >= NB_NODATA) begin
        ev_exec = last_ff == crc_prev_ff;
        ev_pecerr = last_ff != crc_prev_ff;
      end
      ev_rdclr = rd_done_ff && cmd_ff == CMD_STATUS;
    end else if (byte_done) begin
      nxt_sh = nsh;
      nxt_bitcnt = BITS_BYTE;
      nxt_ack = 1'b1;
      nxt_crc = pmc_crc8(crc_ff, nsh);
      if (addr_ph_ff) begin
        nxt_addr_ph = 1'b0;
        if (addr_own && nsh[0]) begin
          nxt_go_tx = 1'b1;
          nxt_tx = rd_data;
          nxt_tx_idx = 1'b0;
          ev_cmderr = !cmd_known(cmd_ff) || nb_ff != 3'h1;
        end else if (!(addr_own || addr_bc) || nsh[0]) begin
          nxt_ack = 1'b0;
          nxt_state = PS_SKIP;
          ev_cmderr = addr_bc;
        end
      end else begin
        nxt_crc_prev = crc_ff;
        nxt_last = nsh;
        nxt_nb = (nb_ff == NB_MAX) ? nb_ff : nb_ff + 3'h1;
        if (nb_ff == 3'h0) nxt_cmd = nsh;
        if (nb_ff == 3'h1) nxt_dat = nsh;
      end
    end else if (bit_ev && (state_ff == PS_RX || state_ff == PS_TX)) begin
      nxt_bitcnt = bitcnt_ff + 4'h1;
      if (state_ff == PS_RX && bitcnt_ff < BITS_BYTE) nxt_sh = nsh;
      if (state_ff == PS_TX && bitcnt_ff == BITS_BYTE - 4'h1) nxt_crc = pmc_crc8(crc_ff, tx_ff);
      if (state_ff == PS_TX && bitcnt_ff == BITS_BYTE) begin
        if (bit_ff) begin
          nxt_state = PS_SKIP;
          nxt_rd_done = tx_idx_ff;
        end else begin
          nxt_tx = crc_ff;
          nxt_tx_idx = 1'b1;
        end
      end
    end else if (scl_fall && (state_ff == PS_RX || state_ff == PS_TX)) begin
      if (bitcnt_ff == BITS_BYTE) begin
        nxt_sda_oe = state_ff == PS_RX && ack_ff;
      end else if (bitcnt_ff == BIT_ACK) begin
        nxt_bitcnt = 4'h0;
        nxt_sda_oe = (state_ff == PS_TX || go_tx_ff) && !tx_ff[7];
        if (go_tx_ff) nxt_state = PS_TX;
        nxt_go_tx = 1'b0;
      end else if (state_ff == PS_TX) begin
        nxt_sda_oe = !tx_ff[3'h7 - bitcnt_ff[2:0]];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_ff <= PS_IDLE;
      bitcnt_ff <= 4'h0;
      sda_oe_ff <= 1'b0;
      go_tx_ff <= 1'b0;
      rd_done_ff <= 1'b0;
      nb_ff <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      bitcnt_ff <= nxt_bitcnt;
      sda_oe_ff <= nxt_sda_oe;
      go_tx_ff <= nxt_go_tx;
      rd_done_ff <= nxt_rd_done;
      nb_ff <= nxt_nb;
    end
  end

  always_ff @(posedge i_clk) begin
    sh_ff <= nxt_sh;
    cmd_ff <= nxt_cmd;
    dat_ff <= nxt_dat;
    last_ff <= nxt_last;
    crc_ff <= nxt_crc;
    crc_prev_ff <= nxt_crc_prev;
    tx_ff <= nxt_tx;
    addr_ph_ff <= nxt_addr_ph;
    ack_ff <= nxt_ack;
    tx_idx_ff <= nxt_tx_idx;
  end

  // ---------------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------------
  wire len_ok = (cmd_ff == CMD_CLEAR) ? nb_ff == NB_NODATA : nb_ff == NB_DATA;
  wire wr_able = cmd_known(cmd_ff) && cmd_ff != CMD_STATUS && cmd_ff != CMD_SETPT;
  wire do_op = ev_exec && len_ok && cmd_ff == CMD_OPERATION;
  wire do_clear = ev_exec && len_ok && cmd_ff == CMD_CLEAR;
  wire do_store = ev_exec && len_ok && cmd_ff == CMD_STORE;
  wire do_margin = ev_exec && len_ok && cmd_ff == CMD_MARGIN;
  wire err_cmd = ev_cmderr || (ev_exec && !wr_able);
  wire err_data = ev_exec && wr_able && !len_ok;

  // ---------------------------------------------------------------------
  // Setpoint, output control and temperature handling
  // ---------------------------------------------------------------------
  logic margin_ff, sw_set_ff, op_on_ff, ar_ff, ar_ld_ff, store_ff, store_ar_ff;
  logic main_on_ff, ot_shut_ff;
  logic [7:0] sw_val_ff;
  logic [CNT_W-1:0] ot_cnt_ff;
  wire off_req = !pins_s_ff.remote_on || !op_on_ff;
  wire ot_expire = pins_s_ff.ot && !ot_shut_ff && ot_cnt_ff == OTW_M1;
  wire ot_release = ot_shut_ff && !pins_s_ff.ot && (ar_ff || off_req);
  wire nxt_main_on = !off_req && !pins_s_ff.interlock && !ot_shut_ff &&
                     !pins_s_ff.ov;
  assign sw_set_ff = margin_ff;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      margin_ff <= 1'b0;
      sw_val_ff <= SETPT_RST;
      op_on_ff <= OP_ON_RST;
      ar_ff <= AR_RST;
      ar_ld_ff <= 1'b0;
      store_ff <= 1'b0;
      store_ar_ff <= AR_RST;
      main_on_ff <= 1'b0;
      ot_shut_ff <= 1'b0;
      ot_cnt_ff <= '0;
      setpoint_ff <= SETPT_RST;
    end else begin
      if (do_margin) margin_ff <= 1'b1;
      if (do_margin) sw_val_ff <= dat_ff;
      if (do_op) op_on_ff <= dat_ff[OP_ON_BIT];
      ar_ld_ff <= 1'b1;
      if (do_store) ar_ff <= dat_ff[STORE_AR_BIT];
      else if (!ar_ld_ff) ar_ff <= i_nvm_auto_restart;
      store_ff <= do_store;
      if (do_store) store_ar_ff <= dat_ff[STORE_AR_BIT];
      main_on_ff <= nxt_main_on;
      ot_cnt_ff <= (pins_s_ff.ot && !ot_shut_ff) ? ot_cnt_ff + CNT_ONE : '0;
      if (ot_expire) ot_shut_ff <= 1'b1;
      else if (ot_release) ot_shut_ff <= 1'b0;
      setpoint_ff <= sw_set_ff ? sw_val_ff : pins_s_ff.vprog;
    end
  end

  // ---------------------------------------------------------------------
  // Status, alert and status pins
  // ---------------------------------------------------------------------
  pmc_cond_type cond, cond_prev_ff;
  logic alert_ff, warn_n_ff, fault_ff, in_ok_ff, out_ok_ff;
  assign cond = '{ot: pins_s_ff.ot | ot_shut_ff, fault: ot_shut_ff | pins_s_ff.ov,
                  in_bad: !pins_s_ff.in_ok, out_bad: !out_ok_ff};
  wire [7:0] stat_set = {1'b0, cond, err_data, err_cmd, ev_pecerr};
  wire [7:0] stat_clr = do_clear ? ALL_MASK : ev_rdclr ? ~COMM_MASK : 8'h00;
  wire comm_ev = err_data | err_cmd | ev_pecerr;
  wire cond_chg = cond != cond_prev_ff;
  wire alert_set = cond_chg | comm_ev | (do_clear && cond != '0);
  wire alert_clr = do_clear | ev_rdclr;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stat_ff <= 8'h00;
      alert_ff <= 1'b0;
      cond_prev_ff <= '0;
      warn_n_ff <= 1'b1;
      fault_ff <= 1'b0;
      in_ok_ff <= 1'b0;
      out_ok_ff <= 1'b0;
    end else begin
      stat_ff <= (stat_ff & ~stat_clr) | stat_set;
      alert_ff <= (alert_ff & ~alert_clr) | alert_set;
      cond_prev_ff <= cond;
      warn_n_ff <= !cond.ot;
      fault_ff <= cond.fault;
      in_ok_ff <= pins_s_ff.in_ok;
      out_ok_ff <= nxt_main_on && pins_s_ff.vout_ok;
    end
  end

  assign o_sda_o = 1'b0;
  assign o_sda_oe = sda_oe_ff;
  assign o_alert_o = 1'b0;
  assign o_alert_oe = alert_ff;
  assign o_setpoint = setpoint_ff;
  assign o_sw_margin = margin_ff;
  assign o_main_on = main_on_ff;
  assign o_ot_warn_n = warn_n_ff;
  assign o_fault = fault_ff;
  assign o_input_in_range_flag = in_ok_ff;
  assign o_output_present_flag = out_ok_ff;
  assign o_nvm_store = store_ff;
  assign o_nvm_auto_restart = store_ar_ff;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_addr_done;
    byte_done && addr_ph_ff && !link_abort && !bus_start && !bus_stop;
  endsequence
  sequence s_addr_foreign;
    s_addr_done ##0 (!addr_own && !addr_bc);
  endsequence

  addr_foreign_a: assert property (
    s_addr_foreign |=> !o_sda_oe [*8]) else $error("foreign address acknowledged");
  own_read_a: assert property (
    s_addr_done ##0 (addr_own && nsh[0]) |=> go_tx_ff && ack_ff)
    else $error("own read address not taken");
  bcast_write_a: assert property (
    s_addr_done ##0 (addr_bc && !nsh[0]) |=> ack_ff && state_ff == PS_RX)
    else $error("broadcast write not acknowledged");
  bcast_read_a: assert property (
    s_addr_done ##0 (addr_bc && nsh[0]) |=> stat_ff[SB_CMD] && state_ff == PS_SKIP)
    else $error("broadcast read not flagged");
  remote_off_a: assert property (
    !pins_s_ff.remote_on |=> !o_main_on) else $error("output on while remote off");
  interlock_hold_a: assert property (
    o_main_on |-> $past(!pins_s_ff.interlock)) else $error("output on without interlock");
  margin_sticky_a: assert property (
    margin_ff |=> margin_ff && o_setpoint == $past(sw_val_ff))
    else $error("margin setpoint lost");
  ot_warn_first_a: assert property (
    $rose(ot_shut_ff) |-> $past(ot_cnt_ff) == OTW_M1 && !o_ot_warn_n)
    else $error("shutdown without warning time");
  read_clear_a: assert property (
    ev_rdclr && !alert_set |=> !o_alert_oe ##0 (stat_ff & COMM_MASK) == $past(stat_ff & COMM_MASK))
    else $error("read-back clear wrong");
  alert_change_a: assert property (
    cond_chg |=> o_alert_oe) else $error("state change without alert");
  bus_stuck_a: assert property (
    stuck |=> state_ff == PS_IDLE && !o_sda_oe) else $error("stuck bus not released");
endmodule  // pmc_ctrl_status

/* verif/pmc_host.sv */
// Serial bus master model for the PSU management controller
`timescale 1ns/10ps
module pmc_host (
  output logic o_scl,
  output logic o_sda_low,
  input wire logic i_sda,
  output logic [7:0] o_rd,
  output logic o_rd_v
);
  logic [7:0] crc = 8'h00;
  initial o_scl = 1'b1;
  initial o_sda_low = 1'b0;
  initial o_rd = 8'h00;
  initial o_rd_v = 1'b0;
  // Bit cell: 1.3 us low then 1.3 us high, data set while clock low
  task automatic bit_io(input logic b, output logic s);
    o_sda_low = !b;
    #650 o_scl = 1'b1;
    #650 s = i_sda;
    #650 o_scl = 1'b0;
    #650;
  endtask
  task automatic start();
    o_sda_low = 1'b0;
    #650 o_scl = 1'b1;
    #650 o_sda_low = 1'b1;
    #650 o_scl = 1'b0;
    #650;
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    #650 o_scl = 1'b1;
    #650 o_sda_low = 1'b0;
    #1300;
  endtask
  // Byte MSB first, check byte kept over what the wire showed
  task automatic byte_io(input logic [7:0] w, input logic mb, output logic [7:0] r,
                         output logic s);
    for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
    bit_io(mb, s);
    crc = crc ^ r;
    for (int i = 0; i < 8; i++) crc = crc[7] ? {crc[6:0], 1'b0} ^ 8'h07 : {crc[6:0], 1'b0};
  endtask
  // Write frame, bad corrupts the check byte
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                    input logic nd, input logic bad, output logic ack);
    logic [7:0] r;
    logic s;
    crc = 8'h00;
    start();
    byte_io({a, 1'b0}, 1'b1, r, s);
    ack = !s;
    byte_io(c, 1'b1, r, s);
    if (nd) byte_io(d, 1'b1, r, s);
    byte_io(crc ^ {7'h00, bad}, 1'b1, r, s);
    stop();
  endtask
  // Read frame; reports data, then check residue (zero when correct)
  task automatic rd(input logic [6:0] a, input logic [7:0] c, input logic note,
                    output logic ack);
    logic [7:0] r;
    logic s;
    crc = 8'h00;
    start();
    byte_io({a, 1'b0}, 1'b1, r, s);
    byte_io(c, 1'b1, r, s);
    start();
    byte_io({a, 1'b1}, 1'b1, r, s);
    ack = !s;
    byte_io(8'hff, 1'b0, r, s);
    o_rd = r;
    if (note) o_rd_v = !o_rd_v;
    byte_io(8'hff, 1'b1, r, s);
    o_rd = crc;
    if (note) o_rd_v = !o_rd_v;
    stop();
  endtask
endmodule // pmc_host

/* verif/testbench.sv */
// Self-checking bench for the PSU management controller
`timescale 1ns/10ps
module testbench;
  import pmc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scl, sda_low, sda_o, sda_oe, al_o, al_oe, margin, main_on, warn_n, fault;
  logic in_f, out_f, nvm_st, nvm_ar, rd_v, ack, remote, ilk, ot, in_ok, ov;
  logic [2:0] strap;
  logic [7:0] vprog, setpt, rd, d;
  logic [7:0] q[$];
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  int n_st = 0;
  int seed;
  wire sda = !(sda_low | sda_oe);
  wire [6:0] own = {ADDR_HI, strap};
  always #12.5 clk = ~clk;
  pmc_host host (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda), .o_rd(rd), .o_rd_v(rd_v));
  pmc_ctrl_status #(.IDLE_CYC(400), .STUCK_CYC(300), .OTW_CYC(50)) uut (
    .i_clk(clk), .i_rst(rst), .i_scl_clk(scl), .i_scl(scl), .i_sda(sda),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_alert_o(al_o), .o_alert_oe(al_oe),
    .i_addr_strap_bit2(strap[2]), .i_addr_strap_bit1(strap[1]),
    .i_addr_strap_bit0(strap[0]), .i_vprog_code(vprog), .o_setpoint(setpt),
    .o_sw_margin(margin), .i_remote_on(remote), .i_interlock(ilk), .o_main_on(main_on),
    .i_ot_cond(ot), .i_ov_shutdown(ov), .i_input_ok(in_ok), .i_vout_ok(main_on),
    .o_ot_warn_n(warn_n), .o_fault(fault), .o_input_in_range_flag(in_f),
    .o_output_present_flag(out_f), .i_nvm_auto_restart(1'b1), .o_nvm_store(nvm_st),
    .o_nvm_auto_restart(nvm_ar));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic st(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rs(input logic [6:0] a, input logic [7:0] c, input logic [7:0] e);
    q.push_back(e);
    q.push_back(8'h00);
    host.rd(a, c, 1'b1, ack);
    chk(ack, 1'b1, "read ack");
    st(8);
  endtask
  always @(rd_v) if (!rst) chk(rd, q.pop_front(), "read byte");
  always @(posedge clk) begin
    n_st <= n_st + int'(nvm_st);
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    seed = 32'h211b;
    strap = $random(seed);
    vprog = $random(seed);
    d = $random(seed);
    {remote, ilk, ot, in_ok, ov} = 5'b10010;
    st(8);
    rst = 1'b0;
    st(8);
    chk(main_on, 1'b1, "main on");
    chk(setpt, vprog, "hw setpoint");
    chk(in_f, 1'b1, "input flag");
    chk({sda_o, al_o}, 8'h00, "open drain low");
    remote = 1'b0;
    st(8);
    chk(main_on, 1'b0, "remote off");
    remote = 1'b1;
    ilk = 1'b1;
    in_ok = 1'b0;
    st(8);
    chk(main_on, 1'b0, "interlock off");
    chk(in_f, 1'b0, "input flag");
    ilk = 1'b0;
    in_ok = 1'b1;
    st(8);
    chk(out_f, 1'b1, "output flag");
    $display("test pins done");
    host.start();
    st(320);
    host.stop();
    host.wr({~ADDR_HI, strap}, CMD_OPERATION, 8'h00, 1'b1, 1'b0, ack);
    chk(ack, 1'b0, "foreign ack");
    host.rd(own, CMD_STATUS, 1'b0, ack);
    chk(ack, 1'b1, "own ack");
    rs(own, CMD_STATUS, 8'h00);
    chk(al_oe, 1'b0, "alert idle");
    host.wr(ADDR_BCAST, CMD_MARGIN, d, 1'b1, 1'b0, ack);
    chk(ack, 1'b1, "bcast ack");
    vprog = ~vprog;
    st(8);
    chk(setpt, d, "margin");
    chk(margin, 1'b1, "margin flag");
    rs(own, CMD_SETPT, d);
    host.rd(ADDR_BCAST, CMD_STATUS, 1'b0, ack);
    chk(ack, 1'b0, "bcast read");
    chk(al_oe, 1'b1, "alert");
    st(80);
    rs(own, CMD_STATUS, 8'h02);
    chk(al_oe, 1'b0, "alert cleared");
    rs(own, CMD_STATUS, 8'h02);
    host.wr(own, CMD_OPERATION, 8'h00, 1'b1, 1'b1, ack);
    st(8);
    chk(main_on, 1'b1, "bad pec");
    host.wr(own, CMD_OPERATION, 8'h00, 1'b1, 1'b0, ack);
    st(8);
    chk(main_on, 1'b0, "cmd off");
    host.wr(own, CMD_OPERATION, 8'h80, 1'b1, 1'b0, ack);
    rs(own, CMD_STATUS, 8'h43);
    chk(al_oe, 1'b0, "alert released");
    rs(own, 8'h55, 8'h00);
    chk(al_oe, 1'b1, "unsupported alert");
    $display("test bus done");
    ot = 1'b1;
    st(8);
    chk({warn_n, main_on}, 8'h01, "ot warn");
    st(60);
    chk({fault, main_on}, 8'h02, "ot stop");
    ot = 1'b0;
    st(8);
    chk({warn_n, fault, main_on}, 8'h05, "ot restart");
    ov = 1'b1;
    st(8);
    chk({fault, main_on}, 8'h02, "ov stop");
    ov = 1'b0;
    st(8);
    chk({fault, main_on}, 8'h01, "ov release");
    host.wr(own, CMD_STORE, 8'h00, 1'b1, 1'b0, ack);
    st(8);
    chk(n_st, 8'h01, "store");
    chk(nvm_ar, 1'b0, "store value");
    rst = 1'b1;
    st(8);
    rst = 1'b0;
    st(8);
    chk(margin, 1'b0, "bias restart flag");
    chk(setpt, vprog, "bias restart");
    $display("test status done");
    stop_test();
  end
endmodule // testbench
